// *** ssi_emul_cfg.svh ***
// Constants for the SSI position output block
// Function
// - Output only when emulation select is 10
// - Position computed from cyclic absolute feedback
// - At most 32 bits per transfer
// - Leading 12..16 revolution bits, LSB last
// - Fixed 16-bit in-turn resolution field follows
// - Gray or binary coding by setting
// - Timing configurable to evaluator clock rate
// - Value rises for clockwise shaft rotation, for counterclockwise with count_ccw set
`ifndef SSI_EMUL_CFG_SVH
`define SSI_EMUL_CFG_SVH

`define SSI_MODE_SSI        4'hA
`define SSI_FOLLOW_SSI      5'h19
`define SSI_WORD_MAX        32
`define SSI_RES_BITS        16
`define SSI_REV_MIN         5'h0C
`define SSI_REV_MAX         5'h10
`define SSI_CLK_HZ          100000000
`define SSI_TIMEOUT_NS      20000
`define SSI_TIMEOUT_CYC     ((`SSI_TIMEOUT_NS * (`SSI_CLK_HZ / 1000000)) / 1000)
`define SSI_FIFO_DEPTH      8

`endif

// *** ssi_emul_pkg.sv ***
// Types for the SSI position output block
package ssi_emul_pkg;

	typedef struct packed {
		logic [15:0] turns;
		logic [15:0] angle;
	} position_t;

	typedef struct packed {
		logic [3:0] emulation_function_select;
		logic [4:0] rev_bits;
		logic       gray_code;
		logic       count_ccw;
		logic [7:0] timeout_scale;
	} ssi_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE  = 2'b10
	} ssi_state_t;

endpackage : ssi_emul_pkg

// *** ssi_pos_fifo.sv ***
// Small valid/ready FIFO for position samples
`timescale 1ns/1ps
`default_nettype none
module ssi_pos_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem[rd_ptr];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (!resetn_i)
		push && !pop |=> count == $past(count) + 1'b1)
		else $error("fifo count did not rise on push");
endmodule : ssi_pos_fifo
`default_nettype wire

// *** ssi_shift_reg.sv ***
// Load-and-shift register for the SSI word
`timescale 1ns/1ps
`default_nettype none
module ssi_shift_reg (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        load_i,
	input  wire logic [31:0] word_i,
	input  wire logic        shift_i,
	output logic             bit_o
);
	logic [31:0] sreg;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sreg <= 32'hFFFFFFFF;
		end else if (load_i) begin
			sreg <= word_i;
		end else if (shift_i) begin
			sreg <= {sreg[30:0], 1'b0};
		end
	end

	assign bit_o = sreg[31];
endmodule : ssi_shift_reg
`default_nettype wire

// *** ssi_position_encoder_emulation.sv ***
// SSI absolute encoder emulation, device side
`timescale 1ns/1ps
`default_nettype none
`include "ssi_emul_cfg.svh"
module ssi_position_encoder_emulation #(
	parameter int TIMEOUT_CYC = `SSI_TIMEOUT_CYC
) (
	input  wire logic                    clk_i,
	input  wire logic                    resetn_i,
	input  wire ssi_emul_pkg::position_t fb_pos_i,
	input  wire logic                    fb_valid_i,
	output logic                         fb_ready_o,
	input  wire ssi_emul_pkg::ssi_cfg_t  cfg_i,
	input  wire logic                    ssi_clk_i,
	output logic                         ssi_data_o,
	output logic                         ssi_data_oe_o,
	output logic                         busy_o
);
	import ssi_emul_pkg::*;

	// ==========================================================
	// Functions
	function automatic logic [31:0] to_gray(input logic [31:0] v);
		to_gray = v ^ (v >> 1);
	endfunction : to_gray

	function automatic logic [4:0] clamp_rev(input logic [4:0] r);
		if (r < `SSI_REV_MIN) begin
			clamp_rev = `SSI_REV_MIN;
		end else if (r > `SSI_REV_MAX) begin
			clamp_rev = `SSI_REV_MAX;
		end else begin
			clamp_rev = r;
		end
	endfunction : clamp_rev

	// ==========================================================
	// Clock pin synchroniser and edge detect
	logic sclk_meta;
	logic sclk_sync;
	logic sclk_prev;
	logic sclk_fall;
	logic sclk_rise;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_meta <= 1'b1;
			sclk_sync <= 1'b1;
			sclk_prev <= 1'b1;
		end else begin
			sclk_meta <= ssi_clk_i;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
		end
	end

	assign sclk_fall = sclk_prev && !sclk_sync;
	assign sclk_rise = !sclk_prev && sclk_sync;

	// ==========================================================
	// Position intake and word build
	position_t   pos_out;
	logic        pos_valid;
	logic        pos_ready;
	position_t   cur_pos;
	logic [31:0] next_word;
	logic [4:0]  rev_n;
	logic [31:0] raw;
	logic        enabled;

	assign enabled = (cfg_i.emulation_function_select == `SSI_MODE_SSI);

	ssi_pos_fifo #(
		.WIDTH($bits(position_t)),
		.DEPTH(`SSI_FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.resetn_i   (resetn_i),
		.in_data_i  (fb_pos_i),
		.in_valid_i (fb_valid_i),
		.in_ready_o (fb_ready_o),
		.out_data_o (pos_out),
		.out_valid_o(pos_valid),
		.out_ready_i(pos_ready)
	);

	assign pos_ready = 1'b1;

	// Latest absolute sample from feedback
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur_pos <= '0;
		end else if (pos_valid) begin
			cur_pos <= pos_out;
		end
	end

	// Word layout: revolutions then 16-bit angle, left aligned
	always_comb begin
		logic [31:0] turns_ext;
		logic [31:0] full;
		turns_ext = 32'h00000000;
		full      = 32'h00000000;
		rev_n     = clamp_rev(cfg_i.rev_bits);
		if (cfg_i.count_ccw) begin
			full = {16'h0000 - cur_pos.turns - 16'(cur_pos.angle != 16'h0000),
				16'h0000 - cur_pos.angle};
		end else begin
			full = {cur_pos.turns, cur_pos.angle};
		end
		turns_ext = 32'(full[31:16] & 16'((17'h1 << rev_n) - 17'h1));
		raw       = (turns_ext << `SSI_RES_BITS) | 32'(full[15:0]);
		if (cfg_i.gray_code) begin
			raw = to_gray(raw);
		end
		next_word = raw << (5'(`SSI_REV_MAX) - rev_n);
	end

	// ==========================================================
	// Transfer sequencer
	ssi_state_t  state;
	logic [5:0]  bit_cnt;
	logic [5:0]  word_len;
	logic [31:0] idle_cnt;
	logic [31:0] timeout_lim;
	logic        load;
	logic        shift;
	logic        timed_out;
	logic        sreg_bit;

	assign word_len    = 6'(`SSI_RES_BITS) + 6'(rev_n);
	assign timeout_lim = 32'(TIMEOUT_CYC) * (32'(cfg_i.timeout_scale) + 32'h1);
	assign timed_out   = (idle_cnt >= timeout_lim);
	assign load        = enabled && (state == ST_IDLE) && sclk_fall;
	assign shift       = (state == ST_SHIFT) && sclk_rise && (bit_cnt != 6'h00);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state   <= ST_IDLE;
			bit_cnt <= 6'h00;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (load) begin
						state   <= ST_SHIFT;
						bit_cnt <= word_len;
					end
				end
				ST_SHIFT: begin
					if (!enabled || timed_out) begin
						state <= ST_IDLE;
					end else if (shift) begin
						bit_cnt <= bit_cnt - 6'h01;
						if (bit_cnt == 6'h01) begin
							state <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					if (timed_out || !enabled) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Clock-quiet counter for monoflop timeout
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idle_cnt <= 32'h00000000;
		end else if (state == ST_IDLE || sclk_fall || sclk_rise || !sclk_sync) begin
			idle_cnt <= 32'h00000000;
		end else if (!timed_out) begin
			idle_cnt <= idle_cnt + 32'h1;
		end
	end

	ssi_shift_reg u_sreg (
		.clk_i   (clk_i),
		.resetn_i(resetn_i),
		.load_i  (load),
		.word_i  (next_word),
		.shift_i (shift),
		.bit_o   (sreg_bit)
	);

	// Data output registered; idle and done show high/low per SSI
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ssi_data_o <= 1'b1;
		end else if (state == ST_DONE) begin
			ssi_data_o <= 1'b0;
		end else if (state == ST_SHIFT) begin
			ssi_data_o <= sreg_bit;
		end else begin
			ssi_data_o <= 1'b1;
		end
	end

	assign ssi_data_oe_o = enabled;
	assign busy_o        = (state != ST_IDLE);

	// ==========================================================
	// Assertions
	a_mode_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!enabled |-> !ssi_data_oe_o && !load)
		else $error("output active outside SSI mode");
	a_load_first_edge: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == ST_IDLE && enabled && sclk_fall |=> state == ST_SHIFT && bit_cnt == $past(word_len))
		else $error("first clock edge did not start transfer");
	a_len_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
		word_len >= 6'h1C && word_len <= 6'h20)
		else $error("word length out of range");
	a_bit_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
		shift && !timed_out && enabled |=> bit_cnt == $past(bit_cnt) - 6'h01)
		else $error("bit counter not stepped");
	a_word_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == ST_SHIFT && !shift && !load |=> $stable(sreg_bit))
		else $error("word changed mid transfer");
	a_res_field: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!cfg_i.gray_code && !cfg_i.count_ccw && rev_n == 5'h10 |-> next_word[15:0] == cur_pos.angle)
		else $error("resolution field misplaced");
	a_gray_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
		cfg_i.gray_code && !cfg_i.count_ccw && rev_n == 5'h10
		|-> next_word == (32'(cur_pos) ^ (32'(cur_pos) >> 1)))
		else $error("gray coding wrong");
	a_rev_lsb: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!cfg_i.gray_code && !cfg_i.count_ccw && rev_n == 5'h0C
		|-> next_word[23:20] == cur_pos.turns[3:0] && next_word[19:4] == cur_pos.angle)
		else $error("revolution LSB not before angle");
	a_cw_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
		pos_valid && !cfg_i.count_ccw |=> cur_pos == $past(pos_out))
		else $error("position not tracked");
	a_timeout_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == ST_DONE && timed_out |=> state == ST_IDLE)
		else $error("timeout did not return to idle");

	// Frame cut short by a quiet clock must not hang in shift
	a_abort_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == ST_SHIFT && timed_out |=> state == ST_IDLE)
		else $error("cut frame did not return to idle");

	// Monoflop phase drives low, idle drives high
	a_done_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == ST_DONE |=> !ssi_data_o)
		else $error("data not low after last bit");
	a_idle_high: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == ST_IDLE |=> ssi_data_o)
		else $error("data not high in idle");

	// Reversed count is the two's complement of the position
	a_ccw_negate: assert property (@(posedge clk_i) disable iff (!resetn_i)
		cfg_i.count_ccw && !cfg_i.gray_code && rev_n == 5'h10
		|-> next_word == 32'h00000000 - 32'(cur_pos))
		else $error("reversed count wrong");

	// Most significant bit leaves first, straight after the latch
	a_msb_first: assert property (@(posedge clk_i) disable iff (!resetn_i)
		load |=> sreg_bit == $past(next_word[31]))
		else $error("first bit is not the MSB");
	a_data_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == ST_SHIFT |=> ssi_data_o == $past(sreg_bit))
		else $error("pin does not follow shift register");

	c_transfer: cover property (@(posedge clk_i) disable iff (!resetn_i) state == ST_SHIFT ##1 state == ST_DONE);
	c_gray: cover property (@(posedge clk_i) disable iff (!resetn_i) load && cfg_i.gray_code);
	c_abort: cover property (@(posedge clk_i) disable iff (!resetn_i) state == ST_SHIFT && timed_out);
	c_ccw: cover property (@(posedge clk_i) disable iff (!resetn_i) load && cfg_i.count_ccw);
endmodule : ssi_position_encoder_emulation
`default_nettype wire

// *** ssi_evaluator_model.sv ***
// Behavioural SSI evaluation unit that clocks words out of the device
`timescale 1ns/1ps
`default_nettype none
`include "ssi_emul_cfg.svh"
module ssi_evaluator_model #(
	parameter logic [4:0] FOLLOW_SELECT = `SSI_FOLLOW_SSI
) (
	input  wire logic ssi_data_i,
	output var logic  ssi_clk_o
);
	// Clock idles high and only toggles within a frame
	initial ssi_clk_o = 1'b1;

	// Fall latches, each bit taken mid high phase, MSB first
	task automatic read_word(input int n, output logic [31:0] w);
		w = '0;
		// Follower reads only when its input select names SSI
		if (FOLLOW_SELECT == `SSI_FOLLOW_SSI) begin
			for (int i = 0; i < n; i++) begin
				ssi_clk_o = 1'b0;
				#40;
				ssi_clk_o = 1'b1;
				#20;
				w = {w[30:0], ssi_data_i};
				#20;
			end
		end
	endtask : read_word
endmodule : ssi_evaluator_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the SSI position output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ssi_emul_pkg::*;
	logic      clk_i = 1'b0;
	logic      resetn_i = 1'b0;
	logic      fb_valid_i = 1'b0;
	position_t fb_pos_i = '0;
	ssi_cfg_t  cfg_i = '0;
	logic      ssi_clk;
	logic      ssi_data_o;
	logic      ssi_data_oe_o;
	logic      busy_o;
	logic      fb_ready_o;
	int        fails = 0;
	int        comparisons = 0;

	always #5 clk_i = ~clk_i;

	ssi_position_encoder_emulation #(.TIMEOUT_CYC(20)) ssi_position_encoder_emulation_inst (
		.clk_i(clk_i), .resetn_i(resetn_i), .fb_pos_i(fb_pos_i), .fb_valid_i(fb_valid_i),
		.fb_ready_o(fb_ready_o), .cfg_i(cfg_i), .ssi_clk_i(ssi_clk), .ssi_data_o(ssi_data_o),
		.ssi_data_oe_o(ssi_data_oe_o), .busy_o(busy_o));
	ssi_evaluator_model ssi_evaluator_model_inst (.ssi_data_i(ssi_data_o), .ssi_clk_o(ssi_clk));

	// ==========================================
	// Shared tasks
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic set_cfg(input logic [3:0] m, input logic [4:0] r, input logic g);
		@(posedge clk_i);
		cfg_i <= '{m, r, g, 1'b0, 8'h01};
	endtask : set_cfg

	task automatic send_pos(input logic [31:0] p);
		@(posedge clk_i);
		fb_pos_i <= p;
		fb_valid_i <= 1'b1;
		@(posedge clk_i);
		fb_valid_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : send_pos

	function automatic logic [31:0] expect_word(input logic [31:0] p, input logic [4:0] r, input logic g);
		logic [31:0] w;
		w = (((p >> 16) & ((32'h1 << r) - 32'h1)) << 16) | {16'h0, p[15:0]};
		return g ? (w ^ (w >> 1)) : w;
	endfunction : expect_word

	// Word, then low until the clock idles past the timeout
	task automatic read_check(input logic [31:0] exp, input int n);
		logic [31:0] w;
		ssi_evaluator_model_inst.read_word(n, w);
		cmp("word", exp, w);
		repeat (26) @(posedge clk_i);
		#1;
		cmp("done_level", 32'h0, {31'h0, ssi_data_o});
		repeat (20) @(posedge clk_i);
		#1;
		cmp("idle_level", 32'h1, {31'h0, ssi_data_o});
		cmp("busy", 32'h0, {31'h0, busy_o});
	endtask : read_check

	// ==========================================
	// Scenarios
	task automatic test_layout();
		for (int r = 12; r <= 16; r += 2) begin
			set_cfg(4'hA, r[4:0], 1'b0);
			send_pos(32'h5ABC1234 + r);
			cmp("oe", 32'h1, {31'h0, ssi_data_oe_o});
			read_check(expect_word(32'h5ABC1234 + r, r[4:0], 1'b0), 16 + r);
		end
		$display("test_layout done");
	endtask : test_layout

	task automatic test_gray();
		set_cfg(4'hA, 5'h10, 1'b1);
		send_pos(32'h00FF8001);
		read_check(expect_word(32'h00FF8001, 5'h10, 1'b1), 32);
		$display("test_gray done");
	endtask : test_gray

	task automatic test_hold();
		logic [31:0] w;
		set_cfg(4'hA, 5'h10, 1'b0);
		send_pos(32'h0003FFFF);
		fork
			ssi_evaluator_model_inst.read_word(32, w);
			begin
				repeat (40) @(posedge clk_i);
				send_pos(32'h00040000);
			end
		join
		cmp("held_word", 32'h0003FFFF, w);
		repeat (50) @(posedge clk_i);
		read_check(32'h00040000, 32);
		$display("test_hold done");
	endtask : test_hold

	task automatic test_off();
		logic [31:0] w;
		set_cfg(4'h9, 5'h10, 1'b0);
		send_pos(32'h12345678);
		ssi_evaluator_model_inst.read_word(8, w);
		cmp("oe_off", 32'h0, {31'h0, ssi_data_oe_o});
		cmp("busy_off", 32'h0, {31'h0, busy_o});
		cmp("fb_ready", 32'h1, {31'h0, fb_ready_o});
		$display("test_off done");
	endtask : test_off

	// Reversed count; a cut frame first must fall back to idle
	task automatic test_ccw();
		logic [31:0] w;
		@(posedge clk_i);
		cfg_i <= '{4'hA, 5'h10, 1'b0, 1'b1, 8'h01};
		send_pos(32'h00020003);
		ssi_evaluator_model_inst.read_word(8, w);
		cmp("cut_bits", 32'hFF, w);
		repeat (60) @(posedge clk_i);
		#1;
		cmp("cut_busy", 32'h0, {31'h0, busy_o});
		read_check(32'h00000000 - 32'h00020003, 32);
		$display("test_ccw done");
	endtask : test_ccw

	task automatic give_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		test_layout();
		test_gray();
		test_hold();
		test_ccw();
		test_off();
		give_verdict();
	end

	// Cuts a hang short well past the expected run
	initial begin
		#500000;
		fails++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
